// file: bench/tb.sv
// bench for the two-wire unit: flag handshake of a master write
// assumes twu_slave on the bus lines, pull-ups on both lines
`timescale 1ns/100ps
`default_nettype none
`include "twu_map.svh"

module tb
	import twu_pkg::*;
;
	localparam int LIMIT = 30000;
	logic       mclk, link_clk, rst_n, c_wr, c_flag, c_start, c_stop, c_en;
	logic       uie, gie, d_wr, nack, op_done, busy, irq, s_scl, s_sda, s_got;
	logic       scl_o, scl_oe_n, sda_o, sda_oe_n, hog;
	logic [7:0] d_in, d_out, status, stretch, s_byte;
	logic [7:0] exp_st[$];
	logic [7:0] exp_b[$];
	logic [31:0] rng;
	int         n_fail, checks, cyc;
	wire        scl_w = scl_oe_n & s_scl;
	wire        sda_w = sda_oe_n & s_sda & ~hog;

	two_wire_unit #(.QTR_CYCLES(4)) u_dut (.mclk_i(mclk), .rst_n_i(rst_n),
		.ctrl_wr_i(c_wr), .ctrl_flag_i(c_flag), .ctrl_start_i(c_start),
		.ctrl_stop_i(c_stop), .ctrl_enable_i(c_en), .unit_irq_enable_i(uie),
		.cpu_global_ie_i(gie), .data_wr_i(d_wr), .data_i(d_in),
		.data_o(d_out), .op_done_o(op_done), .status_o(status),
		.busy_o(busy), .irq_o(irq), .link_clk_i(link_clk), .scl_i(scl_w),
		.scl_o(scl_o), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_n_o(sda_oe_n));

	twu_slave u_slave (.scl_i(scl_w), .sda_i(sda_w), .nack_i(nack),
		.stretch_i(stretch), .scl_rel_o(s_scl), .sda_rel_o(s_sda),
		.byte_o(s_byte), .got_o(s_got));

	// ****************************************************************
	// clocks, checks, drivers
	// ****************************************************************
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	initial begin
		link_clk = 1'b0;
		#7;
		forever #16 link_clk = ~link_clk;
	end

	task automatic give_verdict();
		if (n_fail == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	task automatic cmp8(input string what, input logic [7:0] e,
		input logic [7:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", what, e, g);
		end
	endtask : cmp8

	task automatic cmp1(input string what, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %b got %b", what, e, g);
		end
	endtask : cmp1

	function automatic logic [7:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[7:0];
	endfunction : rnd

	task automatic launch(input logic f, input logic st, input logic en);
		@(negedge mclk);
		c_wr = 1'b1;
		c_flag = f;
		c_start = st;
		c_en = en;
		@(negedge mclk);
		c_wr = 1'b0;
		@(negedge mclk);
	endtask : launch

	// one software step: load byte, clear flag, wait for the event
	task automatic step(input logic st, input logic sp, input logic [7:0] b,
		input logic [7:0] code);
		int n;
		n = 0;
		c_stop = sp;
		if (!st && !sp) begin
			@(negedge mclk);
			d_wr = 1'b1;
			d_in = b;
			@(negedge mclk);
			d_wr = 1'b0;
			cmp8("data_o", b, d_out);
			if (code != `TWU_ST_BUS_ERR && code != `TWU_ST_ARB_LOST)
				exp_b.push_back(b);
		end
		if (!sp) exp_st.push_back(code);
		hog = (code == `TWU_ST_ARB_LOST);
		launch(1'b1, st, 1'b1);
		cmp1("op_done_o", 1'b0, op_done);
		cmp8("status_o", `TWU_ST_IDLE, status);
		if (sp) begin
			while (busy && n < 3000) begin
				@(negedge mclk);
				n++;
			end
			repeat (20) @(negedge mclk);
			cmp1("busy_o", 1'b0, busy);
			cmp1("op_done_o", 1'b0, op_done);
			cmp1("scl", 1'b1, scl_w);
			cmp1("sda", 1'b1, sda_w);
			cmp1("scl_o", 1'b0, scl_o);
			cmp1("sda_o", 1'b0, sda_o);
		end else begin
			while (!op_done && n < 3000) begin
				@(negedge mclk);
				n++;
			end
			hog = 1'b0;
			cmp1("op_done_o", 1'b1, op_done);
			@(negedge mclk);
			cmp1("irq_o", uie & gie, irq);
			repeat (30) @(negedge mclk);
			cmp1("scl", 1'b0, scl_w);
		end
	endtask : step

	// status note is due one cycle after the flag rises
	initial begin
		forever begin
			@(posedge op_done);
			@(negedge mclk);
			cmp8("status_o", `TWU_ST_IDLE, status);
			@(negedge mclk);
			cmp8("status_o", exp_st.size() ? exp_st.pop_front() : 8'hxx,
				status);
		end
	end

	initial begin
		wait (rst_n);
		forever begin
			@(s_got);
			cmp8("slave byte", exp_b.size() ? exp_b.pop_front() : 8'hxx,
				s_byte);
		end
	end

	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			n_fail++;
			give_verdict();
		end
	end

	initial begin
		{rst_n, c_wr, c_flag, c_start, c_stop, c_en, uie, gie} = 8'h00;
		{hog, d_wr, nack, d_in, stretch} = 19'h0_0000;
		{n_fail, checks, cyc} = '0;
		rng = 32'h0000_ecdf;
		repeat (6) @(negedge mclk);
		rst_n = 1'b1;
		repeat (4) @(negedge mclk);
		cmp8("status_o", `TWU_ST_IDLE, status);
		launch(1'b1, 1'b1, 1'b0);
		repeat (100) @(negedge mclk);
		cmp1("busy_o", 1'b0, busy);
		step(1'b0, 1'b0, rnd(), `TWU_ST_BUS_ERR);
		launch(1'b0, 1'b1, 1'b1);
		cmp1("op_done_o", 1'b1, op_done);
		cmp1("busy_o", 1'b0, busy);
		for (int p = 0; p < 3; p++) begin
			uie = (p != 0);
			gie = (p != 1);
			stretch = (p == 2) ? 8'h96 : 8'h00;
			nack = 1'b0;
			step(1'b1, 1'b0, 8'h00, `TWU_ST_START);
			nack = (p == 1);
			step(1'b0, 1'b0, rnd(),
				nack ? `TWU_ST_ADDR_NACK : `TWU_ST_ADDR_ACK);
			if (p != 1) begin
				step(1'b0, 1'b0, rnd(), `TWU_ST_DATA_ACK);
				nack = 1'b1;
				step(1'b0, 1'b0, rnd(), `TWU_ST_DATA_NACK);
			end else begin
				step(1'b0, 1'b0, 8'hFF, `TWU_ST_ARB_LOST);
			end
			step(1'b0, 1'b1, 8'h00, 8'h00);
		end
		cmp1("notes left", 1'b0, (exp_st.size() + exp_b.size()) != 0);
		give_verdict();
	end
endmodule : tb
`default_nettype wire

// file: bench/twu_slave.sv
// bus-side partner: a slave that takes written bytes
// assumes the bench resolves both open-drain lines with pull-ups
`timescale 1ns/100ps
`default_nettype none

module twu_slave (
	// resolved bus lines
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	// behaviour: refuse the byte, clock low stretch in ns
	input  wire logic       nack_i,
	input  wire logic [7:0] stretch_i,
	// line releases, high lets the pull-up win
	output logic            scl_rel_o,
	output logic            sda_rel_o,
	// byte received, toggle per byte
	output logic [7:0]      byte_o,
	output logic            got_o
);
	logic [3:0] nbit;
	logic [7:0] sh;
	logic       ack_q;

	initial begin
		scl_rel_o = 1'b1;
		sda_rel_o = 1'b1;
		byte_o = 8'h00;
		got_o = 1'b0;
		nbit = 4'h0;
		sh = 8'h00;
		ack_q = 1'b0;
	end

	// start or repeated start opens a frame
	always @(negedge sda_i) begin
		if (scl_i) begin
			nbit = 4'h0;
		end
	end

	always @(posedge scl_i) begin
		if (nbit < 4'h8) begin
			sh = {sh[6:0], sda_i};
			nbit = nbit + 4'h1;
		end
	end

	// ack driven only through the ninth clock
	always @(negedge scl_i) begin
		if (ack_q) begin
			sda_rel_o = 1'b1;
			ack_q = 1'b0;
			nbit = 4'h0;
		end else if (nbit == 4'h8) begin
			byte_o = sh;
			got_o = ~got_o;
			sda_rel_o = nack_i;
			ack_q = 1'b1;
		end
		if (stretch_i != 8'h00) begin
			scl_rel_o = 1'b0;
			#(stretch_i);
			scl_rel_o = 1'b1;
		end
	end
endmodule : twu_slave
`default_nettype wire

// file: core/event_sync.sv
// toggle-to-pulse event crossing
// assumes the source flips tg_i once per event, events spaced apart
`timescale 1ns/100ps
`default_nettype none

module event_sync (
	// clock and reset of the receiving side
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// toggle in, one-cycle pulse out
	input  wire logic tg_i,
	output logic      pulse_o
);

	logic tg_s;
	logic last_q;

	sync_2ff #(.WIDTH(1)) u_sync (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.d_i     (tg_i),
		.q_o     (tg_s)
	);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			last_q <= 1'b0;
		end else begin
			last_q <= tg_s;
		end
	end

	assign pulse_o = tg_s ^ last_q;

endmodule : event_sync

`default_nettype wire

// file: core/sync_2ff.sv
// two-flop level synchroniser
// assumes the input is a level from another domain or a pin
`timescale 1ns/100ps
`default_nettype none

module sync_2ff #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// level in and out
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_q;

	initial begin
		if (WIDTH < 1) $error("sync_2ff: WIDTH must be at least 1");
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			q_o    <= '0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end

endmodule : sync_2ff

`default_nettype wire

// file: core/two_wire_unit.sv
// two-wire master transmit unit with software flag handshake
// assumes control ports driven by logic on mclk_i;
// link_clk_i runs free, bus pins are open drain with pull-ups
`timescale 1ns/100ps
`default_nettype none
`include "twu_map.svh"

// Operation
// R1 - irq only when flag, unit and global enables
// R2 - software polls flag when irq disabled
// R3 - flag set after each handled bus event
// R4 - status holds event code while flag set
// R5 - writing one clears flag, zero keeps
// R6 - no new operation while flag set
// R7 - clearing with start request sends start
// R8 - start done sets flag, start code
// R9 - address done: flag, ack or nack code
// R10 - data done: flag, ack or nack code
// R11 - stop done never sets the flag
// R12 - clock line held low while flag set
// R13 - one shift register for address and data
// R14 - software loads data before clearing flag
// R15 - address send writes start bit zero
// R16 - software checks status after each step
// R17 - flag-set write runs the written operation
// R18 - status updated one cycle after flag
// R19 - idle code whenever flag is clear
// R20 - arbitration loss and bus error set flag
// R21 - status codes named in shared constants
module two_wire_unit
	import twu_pkg::*;
#(
	parameter int QTR_CYCLES = `TWU_QTR_CYC
) (
	// system clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_n_i,
	// control write
	input  wire logic       ctrl_wr_i,
	input  wire logic       ctrl_flag_i,
	input  wire logic       ctrl_start_i,
	input  wire logic       ctrl_stop_i,
	input  wire logic       ctrl_enable_i,
	input  wire logic       unit_irq_enable_i,
	input  wire logic       cpu_global_ie_i,
	// shift data register access
	input  wire logic       data_wr_i,
	input  wire logic [7:0] data_i,
	output logic      [7:0] data_o,
	// status and interrupt
	output logic            op_done_o,
	output status_t         status_o,
	output logic            busy_o,
	output logic            irq_o,
	// link clock and bus pins
	input  wire logic       link_clk_i,
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe_n_o,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n_o
);

	initial begin
		if (QTR_CYCLES < 4 || QTR_CYCLES > 255)
			$error("two_wire_unit: QTR_CYCLES must be 4 to 255");
	end

	// ****************************************************************
	// system-side state
	// ****************************************************************
	logic       flag_q;
	logic       pend_q;
	logic       busy_q;
	logic       irq_en_q;
	logic       enable_q;
	logic       addr_next_q;
	logic       cmd_tg_q;
	logic       irq_q;
	cmd_e       cmd_kind_q;
	status_t    status_q;
	logic [7:0] data_q;
	logic       done_p;
	logic       clear_w;
	logic       launch;
	logic       set_w;

	// ****************************************************************
	// link-side state
	// ****************************************************************
	link_state_e l_state_q;
	cmd_e        kind_l_q;
	logic [1:0]  ph_q;
	logic [7:0]  cnt_q;
	logic [2:0]  bit_q;
	logic [7:0]  shreg_q;
	logic        scl_oe_n_q;
	logic        sda_oe_n_q;
	logic        drv_lo_q;
	logic        done_tg_q;
	logic        quiet_q;
	status_t     res_code_q; // R21
	logic        sda_prev_q;
	logic        scl_s;
	logic        sda_s;
	logic        cmd_p;
	logic        tick;
	logic        stall;
	logic        bus_err;

	// ****************************************************************
	// domain crossings
	// ****************************************************************
	event_sync u_cmd_x (
		.clk_i   (link_clk_i),
		.rst_n_i (rst_n_i),
		.tg_i    (cmd_tg_q),
		.pulse_o (cmd_p)
	);

	event_sync u_done_x (
		.clk_i   (mclk_i),
		.rst_n_i (rst_n_i),
		.tg_i    (done_tg_q),
		.pulse_o (done_p)
	);

	sync_2ff #(.WIDTH(2)) u_pin_sync (
		.clk_i   (link_clk_i),
		.rst_n_i (rst_n_i),
		.d_i     ({scl_i, sda_i}),
		.q_o     ({scl_s, sda_s})
	);

	// ****************************************************************
	// flag, status and interrupt
	// ****************************************************************
	assign clear_w = ctrl_wr_i && ctrl_flag_i;
	assign set_w   = done_p && !quiet_q;
	assign launch  = clear_w && ctrl_enable_i && !busy_o; // R6 R17

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag_q <= 1'b0;
		end else if (set_w) begin
			flag_q <= 1'b1; // R3 R8 R9 R10 R20
		end else if (clear_w) begin
			flag_q <= 1'b0; // R5
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pend_q   <= 1'b0;
			status_q <= `TWU_ST_IDLE;
		end else begin
			pend_q <= set_w;
			if (clear_w && !set_w) begin
				status_q <= `TWU_ST_IDLE; // R19
			end else if (pend_q) begin
				status_q <= res_code_q; // R4 R18
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_en_q <= 1'b0;
			enable_q <= 1'b0;
			irq_q    <= 1'b0;
		end else begin
			if (ctrl_wr_i) begin
				irq_en_q <= unit_irq_enable_i;
				enable_q <= ctrl_enable_i;
			end
			irq_q <= flag_q && irq_en_q && cpu_global_ie_i; // R1
		end
	end

	// ****************************************************************
	// command launch and shift data register
	// ****************************************************************
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_q      <= 1'b0;
			cmd_tg_q    <= 1'b0;
			cmd_kind_q  <= CMD_STOP;
			addr_next_q <= 1'b0;
		end else if (launch) begin
			busy_q   <= 1'b1;
			cmd_tg_q <= ~cmd_tg_q;
			if (ctrl_start_i) begin
				cmd_kind_q  <= CMD_START; // R7
				addr_next_q <= 1'b1;
			end else if (ctrl_stop_i) begin
				cmd_kind_q  <= CMD_STOP;
				addr_next_q <= 1'b0;
			end else if (addr_next_q) begin
				cmd_kind_q  <= CMD_ADDR; // R15
				addr_next_q <= 1'b0;
			end else begin
				cmd_kind_q <= CMD_DATA;
			end
		end else if (done_p) begin
			busy_q <= 1'b0;
		end
	end

	// held still while busy, so the link side may read it
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			data_q <= `TWU_DATA_RST;
		end else if (data_wr_i && !busy_q) begin
			data_q <= data_i; // R13
		end
	end

	assign busy_o    = busy_q;
	assign op_done_o = flag_q;
	assign status_o  = status_q;
	assign irq_o     = irq_q;
	assign data_o    = data_q;

	// ****************************************************************
	// link timing
	// ****************************************************************
	assign stall = (ph_q == 2'd2) && !scl_s;
	assign tick  = (cnt_q == 8'(QTR_CYCLES - 1));
	assign bus_err = (l_state_q == L_BIT || l_state_q == L_ACK) &&
		(ph_q == 2'd3) && scl_s && (sda_s != sda_prev_q);

	always_ff @(posedge link_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_q      <= 8'h00;
			sda_prev_q <= 1'b1;
		end else begin
			sda_prev_q <= sda_s;
			if (l_state_q == L_IDLE || l_state_q == L_HOLD || tick) begin
				cnt_q <= 8'h00;
			end else if (!stall) begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end

	// ****************************************************************
	// link engine
	// ****************************************************************
	always_ff @(posedge link_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			l_state_q  <= L_IDLE;
			kind_l_q   <= CMD_STOP;
			ph_q       <= 2'd0;
			bit_q      <= 3'd7;
			shreg_q    <= 8'h00;
			scl_oe_n_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
			drv_lo_q   <= 1'b0;
			done_tg_q  <= 1'b0;
			quiet_q    <= 1'b1;
			res_code_q <= `TWU_ST_IDLE;
		end else if (l_state_q == L_IDLE || l_state_q == L_HOLD) begin
			if (cmd_p) begin
				ph_q     <= 2'd0;
				bit_q    <= 3'd7;
				kind_l_q <= cmd_kind_q;
				shreg_q  <= data_q; // R13
				case (cmd_kind_q)
					CMD_START: begin
						l_state_q <= L_START; // R7
					end
					CMD_STOP: begin
						if (l_state_q == L_HOLD) begin
							l_state_q <= L_STOP;
						end else begin
							done_tg_q <= ~done_tg_q;
							quiet_q   <= 1'b1;
						end
					end
					default: begin
						if (l_state_q == L_HOLD) begin
							l_state_q <= L_BIT;
						end else begin
							done_tg_q  <= ~done_tg_q;
							quiet_q    <= 1'b0;
							res_code_q <= `TWU_ST_BUS_ERR;
							l_state_q  <= L_HOLD;
							scl_oe_n_q <= 1'b0; // R12
						end
					end
				endcase
			end
		end else if (bus_err) begin
			scl_oe_n_q <= 1'b0; // R12
			sda_oe_n_q <= 1'b1;
			l_state_q  <= L_HOLD;
			done_tg_q  <= ~done_tg_q; // R20
			quiet_q    <= 1'b0;
			res_code_q <= `TWU_ST_BUS_ERR;
		end else if (tick && !stall) begin
			ph_q <= ph_q + 2'd1;
			case (l_state_q)
				L_START: begin
					case (ph_q)
						2'd0: sda_oe_n_q <= 1'b1;
						2'd1: scl_oe_n_q <= 1'b1;
						2'd2: sda_oe_n_q <= 1'b0;
						default: begin
							scl_oe_n_q <= 1'b0;
							l_state_q  <= L_HOLD;
							done_tg_q  <= ~done_tg_q;
							quiet_q    <= 1'b0;
							res_code_q <= `TWU_ST_START; // R8
						end
					endcase
				end
				L_BIT: begin
					case (ph_q)
						2'd0: sda_oe_n_q <= shreg_q[7];
						2'd1: scl_oe_n_q <= 1'b1;
						2'd2: begin
							if (shreg_q[7] && !sda_s) begin
								scl_oe_n_q <= 1'b0; // R12
								sda_oe_n_q <= 1'b1;
								l_state_q  <= L_HOLD;
								done_tg_q  <= ~done_tg_q; // R20
								quiet_q    <= 1'b0;
								res_code_q <= `TWU_ST_ARB_LOST;
							end
						end
						default: begin
							scl_oe_n_q <= 1'b0;
							shreg_q    <= {shreg_q[6:0], 1'b0};
							bit_q      <= bit_q - 3'd1;
							if (bit_q == 3'd0) begin
								l_state_q <= L_ACK;
							end
						end
					endcase
				end
				L_ACK: begin
					case (ph_q)
						2'd0: sda_oe_n_q <= 1'b1;
						2'd1: scl_oe_n_q <= 1'b1;
						2'd2: sda_oe_n_q <= 1'b1;
						default: begin
							scl_oe_n_q <= 1'b0; // R12
							l_state_q  <= L_HOLD;
							done_tg_q  <= ~done_tg_q;
							quiet_q    <= 1'b0;
							if (kind_l_q == CMD_ADDR) begin
								res_code_q <= sda_s ? `TWU_ST_ADDR_NACK :
									`TWU_ST_ADDR_ACK; // R9
							end else begin
								res_code_q <= sda_s ? `TWU_ST_DATA_NACK :
									`TWU_ST_DATA_ACK; // R10
							end
						end
					endcase
				end
				L_STOP: begin
					case (ph_q)
						2'd0: sda_oe_n_q <= 1'b0;
						2'd1: scl_oe_n_q <= 1'b1;
						2'd2: sda_oe_n_q <= 1'b1;
						default: begin
							l_state_q <= L_IDLE;
							done_tg_q <= ~done_tg_q;
							quiet_q   <= 1'b1; // R11
						end
					endcase
				end
				default: l_state_q <= L_IDLE;
			endcase
		end
	end

	assign scl_o      = drv_lo_q;
	assign sda_o      = drv_lo_q;
	assign scl_oe_n_o = scl_oe_n_q;
	assign sda_oe_n_o = sda_oe_n_q;

	// ****************************************************************
	// assertions
	// ****************************************************************
	AST_IRQ_GATE: assert property ( // R1
		@(posedge mclk_i) disable iff (!rst_n_i)
		(flag_q && irq_en_q && cpu_global_ie_i) |=> irq_o)
		else $error("irq not raised for enabled flag");

	AST_IRQ_MASK: assert property ( // R1
		@(posedge mclk_i) disable iff (!rst_n_i)
		!(irq_en_q && cpu_global_ie_i) |=> !irq_o)
		else $error("irq raised while disabled");

	AST_DONE_FLAG: assert property ( // R3
		@(posedge mclk_i) disable iff (!rst_n_i)
		set_w |=> op_done_o ##1 (status_o == $past(res_code_q)))
		else $error("event did not set flag and code");

	AST_STATUS_LAG: assert property ( // R18
		@(posedge mclk_i) disable iff (!rst_n_i)
		($rose(flag_q) && !clear_w) |-> ##1 (status_q != `TWU_ST_IDLE))
		else $error("status not updated one cycle after flag");

	AST_IDLE_CODE: assert property ( // R19
		@(posedge mclk_i) disable iff (!rst_n_i)
		!flag_q |-> (status_q == `TWU_ST_IDLE))
		else $error("status not idle while flag clear");

	AST_CLEAR_ONE: assert property ( // R5
		@(posedge mclk_i) disable iff (!rst_n_i)
		(clear_w && !set_w) |=> !flag_q)
		else $error("writing one did not clear flag");

	AST_KEEP_ZERO: assert property ( // R5
		@(posedge mclk_i) disable iff (!rst_n_i)
		(flag_q && !clear_w) |=> flag_q)
		else $error("flag lost without a clearing write");

	AST_NO_LAUNCH: assert property ( // R6
		@(posedge mclk_i) disable iff (!rst_n_i)
		(flag_q && !clear_w) |=> $stable(cmd_tg_q))
		else $error("operation began while flag set");

	AST_START_GO: assert property ( // R7
		@(posedge mclk_i) disable iff (!rst_n_i)
		(launch && ctrl_start_i) |=>
			(busy_o && cmd_kind_q == CMD_START && $changed(cmd_tg_q)))
		else $error("start request not launched");

	AST_STOP_QUIET: assert property ( // R11
		@(posedge mclk_i) disable iff (!rst_n_i)
		(done_p && busy_q && cmd_kind_q == CMD_STOP && !flag_q)
			|=> !op_done_o)
		else $error("flag set after stop");

	AST_SCL_HELD: assert property ( // R12
		@(posedge link_clk_i) disable iff (!rst_n_i)
		(l_state_q == L_HOLD) |-> !scl_oe_n_o)
		else $error("clock line released while waiting");

	COV_START: cover property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		pend_q && res_code_q == `TWU_ST_START);

	COV_ADDR_ACK: cover property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		pend_q && res_code_q == `TWU_ST_ADDR_ACK);

	COV_DATA_ACK: cover property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		pend_q && res_code_q == `TWU_ST_DATA_ACK);

	COV_STOP: cover property (
		@(posedge mclk_i) disable iff (!rst_n_i)
		done_p && quiet_q && cmd_kind_q == CMD_STOP);

endmodule : two_wire_unit

`default_nettype wire

// file: inc/twu_map.svh
// constants of the two-wire unit: status codes, commands, link timing
// assumes inclusion by bare name from package and design files
`ifndef TWU_MAP_SVH
`define TWU_MAP_SVH

// ****************************************************************
// status codes (values arbitrary, chosen for this block)
// ****************************************************************
`define TWU_ST_IDLE      8'h0F
`define TWU_ST_START     8'h01
`define TWU_ST_ADDR_ACK  8'h02
`define TWU_ST_ADDR_NACK 8'h03
`define TWU_ST_DATA_ACK  8'h04
`define TWU_ST_DATA_NACK 8'h05
`define TWU_ST_ARB_LOST  8'h06
`define TWU_ST_BUS_ERR   8'h07

// ****************************************************************
// command encodings
// ****************************************************************
`define TWU_CMD_START 2'h0
`define TWU_CMD_ADDR  2'h1
`define TWU_CMD_DATA  2'h2
`define TWU_CMD_STOP  2'h3

// ****************************************************************
// reset values and link timing
// ****************************************************************
`define TWU_DATA_RST  8'h00
`define TWU_QTR_CYC   8

`endif

// file: inc/twu_pkg.sv
// types shared by the two-wire unit
// assumes twu_map.svh on the include path
`default_nettype none
`include "twu_map.svh"

package twu_pkg;

	typedef logic [7:0] status_t;

	typedef enum logic [1:0] {
		CMD_START = `TWU_CMD_START,
		CMD_ADDR  = `TWU_CMD_ADDR,
		CMD_DATA  = `TWU_CMD_DATA,
		CMD_STOP  = `TWU_CMD_STOP
	} cmd_e;

	typedef enum logic [2:0] {
		L_IDLE  = 3'h0,
		L_START = 3'h1,
		L_BIT   = 3'h3,
		L_ACK   = 3'h2,
		L_HOLD  = 3'h6,
		L_STOP  = 3'h7
	} link_state_e;

endpackage : twu_pkg

`default_nettype wire
